/* File: fifo_direct_host_bus_port_tb.sv */
// self-checking bench joining the host and device ends of the host bus
`timescale 1ns/1ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e); end end
module fifo_direct_host_bus_port_tb;
    import hb_pkg::*;
    logic i_clk = 0;
    logic i_sys_rst = 1;
    int errors = 0;
    int cmp_count = 0;
    logic cmd_valid = 0, cmd_write = 0, cmd_fifo = 0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic [LEN_W-1:0] cmd_len = '0;
    logic [CFG_W-1:0] cfg;
    logic cmd_ready, rd_valid, rd_last, rx_ready, rx_valid, tx_valid, reg_wr, ovr, unr, drop;
    logic [DATA_W-1:0] rd_data, tx_data, reg_wdata, rx_data, reg_rdata;
    logic [ADDR_W-1:0] reg_addr;
    logic [LANE_W-1:0] lane;
    logic [CFG_W-1:0] dev_cfg;
    logic tx_ready = 0;
    logic reg_rd, dev_rst, reset_req = 0;
    int tx_mode = 1;
    int rx_idx = 0, rx_avail = 0, n_ovr = 0, n_unr = 0, n_drop = 0, n_rrd = 0;
    logic [DATA_W-1:0] rx_words [64];
    logic [DATA_W:0] exp_rd [$];
    logic [DATA_W-1:0] exp_tx [$];
    logic [ADDR_W+DATA_W-1:0] exp_wr [$];

    hb_if bus_if ();
    hb_host hb_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus_if.host),
        .i_reset_req(reset_req), .i_config(cfg), .i_cmd_valid(cmd_valid),
        .o_cmd_ready(cmd_ready),
        .i_cmd_write(cmd_write), .i_cmd_fifo(cmd_fifo), .i_cmd_addr(cmd_addr),
        .i_cmd_wdata(cmd_wdata), .i_cmd_len(cmd_len), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_rd_last(rd_last));
    hb_device hb_device_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus_if.device),
        .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_rx_data(rx_data),
        .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_data(tx_data), .o_reg_rd(reg_rd),
        .o_reg_wr(reg_wr), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
        .i_reg_rdata(reg_rdata), .o_fifo_lane(lane), .o_config(dev_cfg), .o_dev_reset(dev_rst),
        .o_burst_overrun(ovr), .o_rx_underrun(unr), .o_tx_drop(drop));
    hb_chk hb_chk_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .select_n(bus_if.select_n),
        .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .fifo_sel(bus_if.fifo_sel), .addr(bus_if.addr), .host_data(bus_if.host_data),
        .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
        .pin_reset_n(bus_if.pin_reset_n), .config_strap(bus_if.config_strap));

    initial forever #50 i_clk = ~i_clk;
    // register file stand-in: read data is a pure function of the address
    assign reg_rdata = {~reg_addr, 9'h05a};
    assign rx_valid = rx_idx < rx_avail;
    assign rx_data = rx_words[rx_idx[5:0]];
    always @(posedge i_clk) begin
        if (rx_valid && rx_ready)
            rx_idx <= #1 rx_idx + 1;
        tx_ready <= #1 (tx_mode == 2) ? 1'($urandom % 2) : tx_mode[0];
    end

    // mid-cycle sampling keeps the registered pulses clear of edge races
    always @(negedge i_clk) begin
        logic [DATA_W:0] e;
        logic [ADDR_W+DATA_W-1:0] w;
        logic [DATA_W-1:0] t;
        if (rd_valid === 1'b1) begin
            e = exp_rd.size() ? exp_rd.pop_front() : 'x;
            `CHK({rd_last, rd_data}, e, "read word")
        end
        if (reg_wr === 1'b1) begin
            w = exp_wr.size() ? exp_wr.pop_front() : 'x;
            `CHK({reg_addr, reg_wdata}, w, "register write")
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            t = exp_tx.size() ? exp_tx.pop_front() : 'x;
            `CHK(tx_data, t, "tx fifo word")
        end
        if (ovr === 1'b1) n_ovr++;
        if (unr === 1'b1) n_unr++;
        if (drop === 1'b1) n_drop++;
        if (reg_rd === 1'b1) n_rrd++;
    end

    task automatic cmd(input logic wr, input logic f, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic [LEN_W-1:0] n);
        int k = 0;
        @(posedge i_clk);
        #1;
        {cmd_write, cmd_fifo, cmd_addr, cmd_wdata, cmd_len} = {wr, f, a, d, n};
        cmd_valid = 1;
        while (cmd_ready !== 1'b1 && k < 400) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        `CHK(cmd_ready, 1'b1, "command not taken")
        @(posedge i_clk);
        #1;
        cmd_valid = 0;
    endtask

    task automatic drain(input string name);
        int k = 0;
        while ((exp_rd.size() + exp_tx.size() + exp_wr.size() != 0 || cmd_ready !== 1'b1)
                && k < 3000) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        `CHK(exp_rd.size() + exp_tx.size() + exp_wr.size(), 0, "results missing")
        `CHK(cmd_ready, 1'b1, "host not idle")
        $display("test %s done", name);
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (8000) @(posedge i_clk);
        errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        void'($urandom(69));
        cfg = 4'($urandom);
        for (int i = 0; i < 64; i++)
            rx_words[i] = 16'($urandom);
        repeat (12) @(posedge i_clk);
        #1 i_sys_rst = 0;
        drain("reset");
        repeat (4) @(posedge i_clk);
        #1;
        `CHK(dev_cfg, cfg, "strap capture")
        `CHK(dev_rst, 1'b0, "device reset level")
        for (int i = 0; i < 3; i++) begin
            a = 7'($urandom);
            d = 16'($urandom);
            exp_wr.push_back({a, d});
            cmd(1, 0, a, d, 8'd1);
        end
        drain("programmed writes");
        a = 7'h10;
        for (int i = 0; i < 16; i++)
            exp_rd.push_back({i == 15, ~(a + 7'(i)), 9'h05a});
        cmd(0, 0, a, '0, 8'd20);
        drain("programmed burst");
        `CHK(n_ovr, 0, "burst overrun")
        `CHK(n_rrd, 16, "register reads")
        rx_avail = 20;
        a = {5'($urandom), 2'b01};
        for (int i = 0; i < 20; i++)
            exp_rd.push_back({i == 19, rx_words[i]});
        cmd(0, 1, a, '0, 8'd20);
        drain("fifo burst");
        `CHK(lane, 2'(a + 7'd19), "fifo lane")
        `CHK(n_rrd, 16, "fifo reads skip registers")
        tx_mode = 2;
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            exp_tx.push_back(d);
            cmd(1, 1, 7'($urandom), d, 8'd1);
        end
        tx_mode = 1;
        drain("fifo writes");
        tx_mode = 0;
        for (int i = 0; i < 3; i++) begin
            if (i < 2)
                exp_tx.push_back(16'h00a0 + 16'(i));
            cmd(1, 1, 7'h00, 16'h00a0 + 16'(i), 8'd1);
        end
        repeat (15) @(posedge i_clk);
        #1;
        `CHK(n_drop, 1, "tx drop count")
        tx_mode = 1;
        drain("tx stall");
        exp_rd.push_back({1'b1, 16'h0000});
        cmd(0, 1, 7'h00, '0, 8'd1);
        drain("rx empty");
        repeat (3) @(posedge i_clk);
        `CHK(n_unr, 1, "rx underrun count")
        // a second pin reset in mid-run must pick up changed straps
        #1;
        cfg = ~cfg;
        reset_req = 1;
        @(posedge i_clk);
        #1 reset_req = 0;
        repeat (3) @(posedge i_clk);
        #1;
        `CHK(dev_rst, 1'b1, "device reset during pin reset")
        drain("pin reset");
        repeat (4) @(posedge i_clk);
        #1;
        `CHK(dev_cfg, cfg, "strap recapture")
        end_of_test();
    end
endmodule

/* File: hb_chk.sv */
// assertion checker for the host bus pins between the host and device ends
`timescale 1ns/1ps
module hb_chk
    import hb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic fifo_sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] host_data,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic pin_reset_n,
    input wire logic [CFG_W-1:0] config_strap
);
    logic rd_act;
    logic wr_act;
    logic bus_act;
    assign rd_act = !select_n && !read_strobe_n;
    assign wr_act = !select_n && !write_strobe_n;
    assign bus_act = rd_act || wr_act;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // the turn-off lags the pins by the synchroniser depth plus the device state register
    oe_read_only_a: assert property (
        !dev_data_oe_n |-> $past(rd_act) || $past(rd_act, 2) || $past(rd_act, 3))
        else $error("device drives bus outside a read");
    read_answer_a: assert property (
        $rose(rd_act) |-> ##[1:4] !dev_data_oe_n)
        else $error("read not answered in time");
    oe_release_a: assert property (
        $fell(rd_act) |-> ##[1:4] dev_data_oe_n)
        else $error("bus not released after read");
    no_contention_a: assert property (
        !dev_data_oe_n |-> host_data_oe_n)
        else $error("both ends drive the bus");
    write_drive_a: assert property (
        wr_act |-> !host_data_oe_n)
        else $error("write without host data");
    write_quiet_a: assert property (
        wr_act && $past(wr_act) |-> dev_data_oe_n)
        else $error("device drives during write");
    write_hold_a: assert property (
        wr_act && $past(wr_act) |-> $stable(addr) && $stable(host_data))
        else $error("write address or data moved");
    write_gap_a: assert property (
        $fell(wr_act) |=> !wr_act [*2])
        else $error("no gap between writes");
    fifo_sel_hold_a: assert property (
        bus_act && $past(bus_act) |-> $stable(fifo_sel))
        else $error("fifo select moved in a cycle");
    strap_hold_a: assert property (
        $rose(pin_reset_n) |-> $stable(config_strap))
        else $error("straps moved at reset release");
endmodule

/* File: hb_device.sv */
// device end of the host bus: programmed access and direct rx/tx fifo paths
// Functional notes
// RULE_01: fifo mode skips upper decode, reads rx fifo
// RULE_02: fifo select high picks direct fifo read
// RULE_03: fifo reads keep A[2:1], ignore A[7:3]
// RULE_04: direct fifo bursts have no length limit
// RULE_05: burst runs while select and read low
// RULE_06: host times fifo select like address
// RULE_07: one write per cycle, strobe returns high
// RULE_08: write runs while select and write low
// RULE_09: fifo select write pushes tx fifo
// RULE_10: tx fifo write framed like programmed write
// RULE_11: data bus is 16 bits everywhere
// RULE_12: straps captured at pin reset rising edge
// RULE_13: programmed bursts stop after 16 words
// RULE_14: host waits 165 ns before level info
// RULE_15: drive bus only during active read
`timescale 1ns/1ps

module hb_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PTR_W:0] count, next_count;
    logic push, pop;

    // refused at elaboration: the pointers wrap only on a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : depth_check
        $error("hb_buffer depth must be a power of two, at least 2");
    end

    assign o_in_ready = (count != (PTR_W + 1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset; only entries counted as valid are ever read
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule

module hb_device (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    hb_if.device bus,
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    input wire logic [hb_pkg::DATA_W-1:0] i_rx_data,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic [hb_pkg::DATA_W-1:0] o_tx_data,
    output logic o_reg_rd,
    output logic o_reg_wr,
    output logic [hb_pkg::ADDR_W-1:0] o_reg_addr,
    output logic [hb_pkg::DATA_W-1:0] o_reg_wdata,
    input wire logic [hb_pkg::DATA_W-1:0] i_reg_rdata,
    output logic [hb_pkg::LANE_W-1:0] o_fifo_lane,
    output logic [hb_pkg::CFG_W-1:0] o_config,
    output logic o_dev_reset,
    output logic o_burst_overrun,
    output logic o_rx_underrun,
    output logic o_tx_drop
);
    import hb_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } dev_state_t;

    localparam int PIN_W = 5 + ADDR_W + DATA_W + CFG_W;
    // strobes and pin reset rest high, so the idle bus is seen right after reset
    localparam logic [PIN_W-1:0] PIN_RST = {3'b111, 1'b0, {ADDR_W{1'b0}},
        {DATA_W{1'b0}}, 1'b1, {CFG_W{1'b0}}};

    logic [PIN_W-1:0] pin_raw, pin_s1, pin_s2;
    logic sel_n, rd_n, wr_n, fsel, prst_n;
    logic [ADDR_W-1:0] adr, adr_prev;
    logic [DATA_W-1:0] din;
    logic [CFG_W-1:0] strap;
    logic prst_prev;

    dev_state_t state, next_state;
    logic mode_fifo, next_mode_fifo;
    logic [BURST_W-1:0] words, next_words;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [ADDR_W-1:0] cyc_addr, next_cyc_addr;
    logic [LANE_W-1:0] lane, next_lane;
    logic [CFG_W-1:0] cfg, next_cfg;
    logic next_reg_wr, next_overrun, next_underrun, next_drop;
    logic fetch, fetch_fifo;
    logic rx_out_valid, rx_pop;
    logic [DATA_W-1:0] rx_out_data;
    logic tx_in_ready, tx_push;

    // every pin passes two flip-flops before any logic looks at it
    assign pin_raw = {bus.select_n, bus.read_strobe_n, bus.write_strobe_n, bus.fifo_sel,
        bus.addr, bus.data_bus, bus.pin_reset_n, bus.config_strap};
    assign {sel_n, rd_n, wr_n, fsel, adr, din, prst_n, strap} = pin_s2;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_s1 <= PIN_RST;
            pin_s2 <= PIN_RST;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    hb_buffer #(.WIDTH(DATA_W), .DEPTH(2)) u_rx_buf (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_rx_valid),
        .o_in_ready(o_rx_ready),
        .i_in_data(i_rx_data),
        .o_out_valid(rx_out_valid),
        .i_out_ready(rx_pop),
        .o_out_data(rx_out_data)
    );

    hb_buffer #(.WIDTH(DATA_W), .DEPTH(2)) u_tx_buf (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(tx_push),
        .o_in_ready(tx_in_ready),
        .i_in_data(wdata),
        .o_out_valid(o_tx_valid),
        .i_out_ready(i_tx_ready),
        .o_out_data(o_tx_data)
    );

    always_comb begin
        next_state = state;
        next_mode_fifo = mode_fifo;
        next_words = words;
        next_rdata = rdata;
        next_wdata = wdata;
        next_cyc_addr = cyc_addr;
        next_lane = lane;
        next_cfg = cfg;
        next_reg_wr = 1'b0;
        next_overrun = 1'b0;
        next_underrun = 1'b0;
        next_drop = 1'b0;
        fetch = 1'b0;
        fetch_fifo = 1'b0;
        tx_push = 1'b0;
        if (prst_n && !prst_prev) begin
            next_cfg = strap; // RULE_12
        end
        case (state)
            ST_IDLE: begin
                if (!sel_n && !rd_n) begin // RULE_05
                    next_state = ST_READ;
                    next_mode_fifo = fsel; // RULE_02
                    next_words = '0;
                    fetch = 1'b1;
                    fetch_fifo = fsel;
                end else if (!sel_n && !wr_n) begin // RULE_08
                    next_state = ST_WRITE;
                    next_mode_fifo = fsel; // RULE_09
                    next_cyc_addr = adr;
                    next_wdata = din;
                end
            end
            ST_READ: begin
                if (sel_n || rd_n) begin // RULE_05
                    next_state = ST_IDLE;
                end else if (adr != adr_prev) begin
                    // a new address inside a held strobe is the next burst word
                    if (mode_fifo) begin
                        fetch = 1'b1; // RULE_04
                        fetch_fifo = 1'b1;
                    end else if (words == BURST_W'(BURST_MAX - 1)) begin
                        next_overrun = 1'b1; // RULE_13
                        next_rdata = '0;
                    end else begin
                        next_words = words + 1'b1;
                        fetch = 1'b1;
                    end
                end
            end
            ST_WRITE: begin
                // data is taken at the last sample before release
                if (sel_n || wr_n) begin // RULE_10
                    next_state = ST_IDLE; // RULE_07
                    if (mode_fifo) begin
                        tx_push = tx_in_ready; // RULE_09
                        next_drop = !tx_in_ready;
                    end else begin
                        next_reg_wr = 1'b1; // RULE_08
                    end
                end else begin
                    next_wdata = din; // RULE_11
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (fetch) begin
            if (fetch_fifo) begin
                // upper address is not decoded, only the lane bits are kept
                next_lane = adr[LANE_W-1:0]; // RULE_03
                next_rdata = rx_out_valid ? rx_out_data : '0; // RULE_01
                next_underrun = !rx_out_valid;
            end else begin
                next_cyc_addr = adr;
                next_rdata = i_reg_rdata;
            end
        end
    end

    assign rx_pop = fetch && fetch_fifo;
    assign o_reg_rd = fetch && !fetch_fifo;
    assign o_reg_addr = o_reg_rd ? adr : cyc_addr;
    assign o_reg_wdata = wdata;
    assign o_dev_reset = !prst_n;
    // the bus is released as soon as the strobe release is seen
    assign bus.dev_data_oe_n = (state != ST_READ); // RULE_15
    assign bus.dev_data = rdata;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            mode_fifo <= 1'b0;
            words <= '0;
            rdata <= '0;
            wdata <= '0;
            cyc_addr <= '0;
            lane <= '0;
            cfg <= '0;
            adr_prev <= '0;
            prst_prev <= 1'b1;
            o_reg_wr <= 1'b0;
            o_burst_overrun <= 1'b0;
            o_rx_underrun <= 1'b0;
            o_tx_drop <= 1'b0;
        end else begin
            state <= next_state;
            mode_fifo <= next_mode_fifo;
            words <= next_words;
            rdata <= next_rdata;
            wdata <= next_wdata;
            cyc_addr <= next_cyc_addr;
            lane <= next_lane;
            cfg <= next_cfg;
            adr_prev <= adr;
            prst_prev <= prst_n;
            o_reg_wr <= next_reg_wr;
            o_burst_overrun <= next_overrun;
            o_rx_underrun <= next_underrun;
            o_tx_drop <= next_drop;
        end
    end

    assign o_fifo_lane = lane;
    assign o_config = cfg;
endmodule

/* File: hb_host.sv */
// host end of the host bus: reset pulse, straps, single writes and burst reads
`timescale 1ns/1ps
module hb_host (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    hb_if.host bus,
    input wire logic i_reset_req,
    input wire logic [hb_pkg::CFG_W-1:0] i_config,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic i_cmd_write,
    input wire logic i_cmd_fifo,
    input wire logic [hb_pkg::ADDR_W-1:0] i_cmd_addr,
    input wire logic [hb_pkg::DATA_W-1:0] i_cmd_wdata,
    input wire logic [hb_pkg::LEN_W-1:0] i_cmd_len,
    output logic o_rd_valid,
    output logic [hb_pkg::DATA_W-1:0] o_rd_data,
    output logic o_rd_last
);
    import hb_pkg::*;

    typedef enum logic [1:0] {
        HS_RESET = 2'b00,
        HS_IDLE = 2'b01,
        HS_ACCESS = 2'b10,
        HS_RECOVER = 2'b11
    } host_state_t;

    host_state_t state, next_state;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic [LEN_W-1:0] left, next_left;
    logic is_wr, next_is_wr;
    logic [ADDR_W-1:0] addr, next_addr;
    logic fsel, next_fsel;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [CFG_W-1:0] strap, next_strap;
    logic [DATA_W-1:0] rd_data, next_rd_data;
    logic rd_valid, next_rd_valid, rd_last, next_rd_last;
    logic [DATA_W-1:0] din_s1, din_s2;
    logic [LEN_W-1:0] len;

    // programmed bursts are cut to sixteen words; zero length means one word
    always_comb begin
        len = (i_cmd_len == '0) ? LEN_W'(1) : i_cmd_len;
        if (!i_cmd_fifo && len > LEN_W'(BURST_MAX)) begin
            len = LEN_W'(BURST_MAX); // RULE_13
        end
        if (i_cmd_write) begin
            len = LEN_W'(1); // RULE_07
        end
    end

    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_left = left;
        next_is_wr = is_wr;
        next_addr = addr;
        next_fsel = fsel;
        next_wdata = wdata;
        next_strap = strap;
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        next_rd_last = 1'b0;
        if (i_reset_req && state != HS_RESET) begin
            next_state = HS_RESET;
            next_tmr = '0;
        end else begin
            case (state)
                HS_RESET: begin
                    // straps follow i_config on every reset cycle, the last one too, and hold from the release on
                    next_strap = i_config; // RULE_12
                    next_tmr = tmr + 1'b1;
                    if (tmr == TMR_W'(RESET_PULSE_CYC - 1)) begin
                        next_state = HS_RECOVER;
                        next_tmr = '0;
                    end
                end
                HS_IDLE: begin
                    if (i_cmd_valid) begin
                        next_state = HS_ACCESS;
                        next_tmr = '0;
                        next_is_wr = i_cmd_write;
                        next_fsel = i_cmd_fifo; // RULE_06
                        next_addr = i_cmd_addr;
                        next_wdata = i_cmd_wdata;
                        next_left = len;
                    end
                end
                HS_ACCESS: begin
                    next_tmr = tmr + 1'b1;
                    if (tmr == TMR_W'(WORD_CYC - 1)) begin
                        next_tmr = '0;
                        next_left = left - 1'b1;
                        if (!is_wr) begin
                            next_rd_data = din_s2; // RULE_11
                            next_rd_valid = 1'b1;
                            next_rd_last = (left == LEN_W'(1));
                        end
                        if (left == LEN_W'(1)) begin
                            next_state = HS_RECOVER;
                        end else begin
                            // stepping the address marks the next burst word
                            next_addr = addr + 1'b1; // RULE_04
                        end
                    end
                end
                HS_RECOVER: begin
                    // covers the strobe high time and the read after read gap
                    next_tmr = tmr + 1'b1;
                    if (tmr == TMR_W'(RECOVER_CYC - 1)) begin // RULE_14
                        next_state = HS_IDLE;
                        next_tmr = '0;
                    end
                end
                default: begin
                    next_state = HS_RESET;
                    next_tmr = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= HS_RESET;
            tmr <= '0;
            left <= '0;
            is_wr <= 1'b0;
            addr <= '0;
            fsel <= 1'b0;
            wdata <= '0;
            strap <= '0;
            rd_data <= '0;
            rd_valid <= 1'b0;
            rd_last <= 1'b0;
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            left <= next_left;
            is_wr <= next_is_wr;
            addr <= next_addr;
            fsel <= next_fsel;
            wdata <= next_wdata;
            strap <= next_strap;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            rd_last <= next_rd_last;
            din_s1 <= bus.data_bus;
            din_s2 <= din_s1;
        end
    end

    assign o_cmd_ready = (state == HS_IDLE);
    assign o_rd_valid = rd_valid;
    assign o_rd_data = rd_data;
    assign o_rd_last = rd_last;
    assign bus.pin_reset_n = (state != HS_RESET);
    assign bus.config_strap = strap;
    assign bus.select_n = (state != HS_ACCESS);
    assign bus.read_strobe_n = !(state == HS_ACCESS && !is_wr);
    assign bus.write_strobe_n = !(state == HS_ACCESS && is_wr); // RULE_07
    assign bus.fifo_sel = fsel;
    assign bus.addr = addr;
    assign bus.host_data = wdata;
    assign bus.host_data_oe_n = !(state == HS_ACCESS && is_wr);
endmodule

/* File: hb_if.sv */
// pins of the asynchronous 16-bit host bus between host and device
`timescale 1ns/1ps
interface hb_if;
    import hb_pkg::*;
    logic select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic fifo_sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_data;
    logic host_data_oe_n;
    logic [DATA_W-1:0] dev_data;
    logic dev_data_oe_n;
    logic pin_reset_n;
    logic [CFG_W-1:0] config_strap;
    logic [DATA_W-1:0] data_bus;
    // resolved bus level; an undriven bus reads zero here
    assign data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : '0);
    modport device (
        input select_n, read_strobe_n, write_strobe_n, fifo_sel, addr, data_bus,
        input pin_reset_n, config_strap,
        output dev_data, dev_data_oe_n
    );
    modport host (
        output select_n, read_strobe_n, write_strobe_n, fifo_sel, addr, host_data,
        output host_data_oe_n, pin_reset_n, config_strap,
        input data_bus
    );
endinterface

/* File: hb_pkg.sv */
// constants shared by the host bus port ends
package hb_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    localparam int CFG_W = 4;
    localparam int LEN_W = 8;
    localparam int LANE_W = 2;
    localparam int BURST_MAX = 16;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CYCLE_NS = 165;
    localparam int ASSERT_NS = 32;
    localparam int DEASSERT_NS = 13;
    localparam int RAR_NS = 165;
    localparam int STRAP_SETUP_NS = 200;
    localparam int RESET_PULSE_US = 200;
    localparam int CYCLE_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ASSERT_CYC = (ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEASSERT_CYC = (DEASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAR_CYC = (RAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SETUP_CYC = (STRAP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC = RESET_PULSE_US * 1000 / CLK_PERIOD_NS;
    // both ends synchronise pins, so a word needs 2+1 device cycles plus 2+1 host cycles
    localparam int SYNC_STAGES = 2;
    localparam int WORD_CYC = 2 * SYNC_STAGES + 2;
    localparam int RECOVER_CYC = (RAR_CYC > DEASSERT_CYC ? RAR_CYC : DEASSERT_CYC) + 1;
    localparam int TMR_W = 12;
    localparam int BURST_W = 5;
endpackage
